/* File: bench/chan_monitor.sv */
// Purpose: port checks of the serial channel
// Assumes: transmit pin kept in serial NRZ use
// Notes: bound to every channel instance
`timescale 1ns/1ps
module chan_monitor #(parameter bit FLOW_PINS = 1'b1) (
    // clock and reset
    input wire logic        clock,
    input wire logic        sys_rst,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [4:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pins
    input wire logic        tx_pin_o,
    input wire logic        clear_send_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 5'h18
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_start_len: assert property ($fell(tx_pin_o) |-> !tx_pin_o[*8] ##1 !tx_pin_o[*7])
        else $error("start bit short");
    a_reset_idle: assert property ($fell(sys_rst) |-> tx_pin_o) else $error("pin not idle");
    a_second_clear: assert property (!FLOW_PINS |-> clear_send_n) else $error("clear driven");
    a_ctrl_upper: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 5'h08
        |-> wb_dat_o[31:8] == 24'h0) else $error("control upper bits set");
endmodule : chan_monitor
bind async_serial_channel_tx_flow chan_monitor #(.FLOW_PINS(FLOW_PINS)) chan_monitor_inst (.*);

/* File: bench/serial_peer.sv */
// Purpose: remote station looping the transmit line back
// Assumes: pull-up on the receive line
// Notes: request level set by the bench
`timescale 1ns/1ps
module serial_peer (
    // line and flow
    input  wire logic tx_pin_o,
    input  wire logic tx_pin_oe,
    input  wire logic req_level,
    output logic      rx_line,
    output logic      request_n
);
    assign rx_line = tx_pin_oe ? tx_pin_o : 1'b1;
    assign request_n = req_level;
endmodule : serial_peer

/* File: bench/tb_top.sv */
// Purpose: self-checking bench of the serial channel
// Assumes: divisor 0, bit is 16 clocks
// Notes: frames loop back through the peer
`timescale 1ns/1ps
module tb_top;
    import uart_chan_pkg::*;
    logic clock = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, req_level = 1;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic ack, tx_o, tx_oe, rx_line, request_n;
    logic tx2_o, cts_n, cts2_n, txi, rxi, reqi;
    int n_mismatch = 0, cmp_count = 0;
    async_serial_channel_tx_flow async_serial_channel_tx_flow_inst (.clock(clock),
        .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .tx_pin_i(tx_o), .tx_pin_o(tx_o), .tx_pin_oe(tx_oe), .rx_pin_i(rx_line),
        .rx_pin_o(), .rx_pin_oe(), .request_n(request_n), .clear_send_n(cts_n),
        .tx_irq(txi), .rx_irq(rxi), .request_irq(reqi));
    // second channel copy without request and clear functions
    async_serial_channel_tx_flow #(.FLOW_PINS(1'b0)) async_serial_channel_tx_flow_inst2 (
        .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(),
        .tx_pin_i(tx2_o), .tx_pin_o(tx2_o), .tx_pin_oe(), .rx_pin_i(rx_line), .rx_pin_o(),
        .rx_pin_oe(), .request_n(request_n), .clear_send_n(cts2_n), .tx_irq(), .rx_irq(),
        .request_irq());
    serial_peer serial_peer_inst (.tx_pin_o(tx_o), .tx_pin_oe(tx_oe),
        .req_level(req_level), .rx_line(rx_line), .request_n(request_n));
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clock);
        if (i == 20) begin n_mismatch++; report_and_stop(); end
        rdat = dat_o;
        cyc <= 0; stb <= 0;
        @(posedge clock);
    endtask : bus
    task automatic send_recv(input logic [7:0] c2, input logic [31:0] exp);
        bus(1, ADR_CTRL2, {24'h0, c2});
        bus(1, ADR_TXD, 32'h3c);
        repeat (250) @(posedge clock);
        bus(0, ADR_RXD, 0);
        check(rdat, exp);
    endtask : send_recv
    // request raised while the first of two characters is on the line
    task automatic flow_hold();
        send_recv(8'h07, 32'h0);
        bus(1, ADR_TXD, 32'h3c);
        req_level <= 0;
        repeat (40) @(posedge clock);
        req_level <= 1;
        repeat (400) @(posedge clock);
        check({29'h0, reqi, rxi, txi}, 32'h7);
        bus(0, ADR_RXD, 0);
        check(rdat, 32'h83c);
        bus(0, ADR_RXD, 0);
        check(rdat, 32'h0);
        req_level <= 0;
        repeat (250) @(posedge clock);
        bus(0, ADR_STAT, 0);
        check(rdat & 32'h4, 32'h0);
        bus(0, ADR_RXD, 0);
        check(rdat, 32'h83c);
        req_level <= 1;
    endtask : flow_hold
    // sixteen characters fill the receive FIFO, a seventeenth overruns
    task automatic fill_overrun();
        int k;
        bus(1, ADR_CTRL2, 32'h11);
        for (k = 0; k < 16; k++) bus(1, ADR_TXD, 32'h3c);
        repeat (2700) @(posedge clock);
        check({31'h0, cts_n}, 32'h1);
        bus(1, ADR_TXD, 32'h3c);
        repeat (250) @(posedge clock);
        bus(0, ADR_STAT, 0);
        check(rdat & 32'h12, 32'h12);
        bus(1, ADR_CTRL2, 32'h31);
        check({30'h0, cts2_n, cts_n}, 32'h2);
    endtask : fill_overrun
    initial forever #25 clock = ~clock;
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 0;
        bus(0, ADR_CTRL2, 0); check(rdat, 32'h1);
        bus(0, ADR_STAT, 0); check(rdat & 32'h24, 32'h24);
        check({30'h0, cts2_n, cts_n}, 32'h2);
        bus(1, ADR_CTRL1, 32'hf);
        check({29'h0, reqi, rxi, txi}, 32'h1);
        send_recv(8'h11, 32'h83c);
        flow_hold();
        send_recv(8'h97, 32'h93c);
        fill_overrun();
        bus(1, ADR_CTRL1, 32'h21);
        repeat (250) @(posedge clock);
        check({31'h0, tx_o}, 32'h0);
        bus(0, 5'h1c, 0); check(rdat, 32'h0);
        report_and_stop();
    end
endmodule : tb_top

/* File: design/async_serial_channel_tx_flow.sv */
// Purpose: one asynchronous serial channel with flow control and infrared coding
// Assumes: classic Wishbone slave, 20 MHz clock, one clock domain
// Notes:   FLOW_PINS=0 builds the second copy without request and clear pins
`timescale 1ns/1ps
module async_serial_channel_tx_flow
    import uart_chan_pkg::*;
#(
    parameter bit FLOW_PINS = 1'b1
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // serial pins
    input  wire logic        tx_pin_i,
    output logic             tx_pin_o,
    output logic             tx_pin_oe,
    input  wire logic        rx_pin_i,
    output logic             rx_pin_o,
    output logic             rx_pin_oe,
    input  wire logic        request_n,
    output logic             clear_send_n,
    // interrupt requests
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             request_irq
);
    import uart_chan_pkg::*;

    typedef struct packed {
        logic [7:0]       ctrl1;
        logic [7:0]       ctrl2;
        logic [DIV_W-1:0] div;
        logic [5:0]       port;
        logic [DIV_W-1:0] pre;
        logic [3:0]       txsub;
        logic [3:0]       rxsub;
        tx_state_e        tx_st;
        logic [7:0]       tx_sh;
        logic [2:0]       tx_bit;
        logic             tx_par;
        logic             tx_stop2;
        logic             tx_line;
        rx_state_e        rx_st;
        logic [7:0]       rx_sh;
        logic [2:0]       rx_bit;
        logic [1:0]       rx_votes;
        logic             rx_par;
        logic             rx_armed;
        logic [3:0]       ir_cnt;
        logic             rx_push;
        logic [RXW_W-1:0] rx_word;
        logic             req_s1;
        logic             req_s2;
        logic             req_prev;
        logic             rx_s1;
        logic             rx_s2;
        logic             txp_s1;
        logic             txp_s2;
        logic             delta;
        logic             ovr;
        logic             brk_seen;
        logic             ack;
        logic [31:0]      dat;
        logic             tx_o;
        logic             tx_oe;
        logic             rx_o;
        logic             rx_oe;
        logic             cts_n;
        logic             tx_irq;
        logic             rx_irq;
        logic             req_irq;
    } chan_s;

    localparam chan_s ST_RST = '{ctrl1: CTRL1_RST, ctrl2: CTRL2_RST, div: DIV_RST,
                                 port: PORT_RST, tx_line: 1'b1, tx_o: 1'b1, tx_oe: 1'b1,
                                 tx_st: TX_IDLE, rx_st: RX_IDLE,
                                 cts_n: 1'b1, req_s1: 1'b1, req_s2: 1'b1, req_prev: 1'b1,
                                 rx_s1: 1'b1, rx_s2: 1'b1, default: '0};

    chan_s            st_ff;
    chan_s            nxt_st;
    logic             tx_push;
    logic             tx_pop;
    logic             tx_room;
    logic             tx_avail;
    logic [7:0]       tx_head;
    logic             rx_pop;
    logic             rx_room;
    logic             rx_avail;
    logic [RXW_W-1:0] rx_head;

    // ==========================================================
    // FIFOs
    chan_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (tx_push),
        .in_ready  (tx_room),
        .in_data   (wb_dat_i[7:0]),
        .out_valid (tx_avail),
        .out_ready (tx_pop),
        .out_data  (tx_head)
    );

    chan_fifo #(.WIDTH(RXW_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (st_ff.rx_push),
        .in_ready  (rx_room),
        .in_data   (st_ff.rx_word),
        .out_valid (rx_avail),
        .out_ready (rx_pop),
        .out_data  (rx_head)
    );

    // ==========================================================
    // next state
    always_comb begin
        logic       req_take;
        logic       en;
        logic       tick16;
        logic       tick1x;
        logic       eight;
        logic [2:0] last_bit;
        logic       req_go;
        logic       can_start;
        logic       line_in;
        logic       bitv;
        logic [7:0] rdata;
        logic       perr;
        logic       ferr;
        logic       brk;
        logic       tx_val;
        logic [7:0] wr;
        req_take  = wb_cyc_i && wb_stb_i && !st_ff.ack;
        en        = st_ff.ctrl1[C1_EN];
        tick16    = en && (st_ff.pre == '0);
        tick1x    = tick16 && (st_ff.txsub == SUB_LAST);
        eight     = st_ff.ctrl2[C2_EIGHT];
        last_bit  = eight ? 3'h7 : 3'h6;
        req_go    = st_ff.ctrl2[C2_IGN] || !FLOW_PINS || !st_ff.req_s2;
        can_start = tx_avail && req_go && !st_ff.ctrl1[C1_BRK];
        line_in   = 1'b1;
        bitv      = 1'b0;
        rdata     = 8'h00;
        perr      = 1'b0;
        ferr      = 1'b0;
        brk       = 1'b0;
        tx_val    = 1'b1;
        wr        = wb_dat_i[7:0];
        nxt_st    = st_ff;
        tx_push   = 1'b0;
        tx_pop    = 1'b0;
        rx_pop    = 1'b0;

        // pin synchronisers
        nxt_st.req_s1   = request_n;
        nxt_st.req_s2   = st_ff.req_s1;
        nxt_st.req_prev = st_ff.req_s2;
        nxt_st.rx_s1    = rx_pin_i;
        nxt_st.rx_s2    = st_ff.rx_s1;
        nxt_st.txp_s1   = tx_pin_i;
        nxt_st.txp_s2   = st_ff.txp_s1;

        // prescaler and 16x sub-bit counters
        if (en) begin
            nxt_st.pre = (st_ff.pre == '0) ? st_ff.div : st_ff.pre - 1'b1;
        end
        if (tick16) begin
            nxt_st.txsub = st_ff.txsub + 1'b1;
            nxt_st.rxsub = st_ff.rxsub + 1'b1;
        end

        // transmitter, one bit per 1x tick
        if (!en) begin
            nxt_st.tx_st   = TX_IDLE;
            nxt_st.tx_line = 1'b1;
        end else if (tick1x) begin
            case (st_ff.tx_st)
                TX_DATA: begin
                    nxt_st.tx_line = st_ff.tx_sh[0];
                    nxt_st.tx_sh   = {1'b0, st_ff.tx_sh[7:1]};
                    nxt_st.tx_bit  = st_ff.tx_bit + 1'b1;
                    if (st_ff.tx_bit == last_bit) begin
                        nxt_st.tx_st = st_ff.ctrl2[C2_PAR] ? TX_PAR : TX_STOP;
                    end
                end
                TX_PAR: begin
                    nxt_st.tx_line = st_ff.tx_par;
                    nxt_st.tx_st   = TX_STOP;
                end
                TX_STOP: begin
                    nxt_st.tx_line  = 1'b1;
                    nxt_st.tx_stop2 = st_ff.ctrl2[C2_TWO];
                    nxt_st.tx_st    = TX_END;
                end
                default: begin
                    if (st_ff.tx_st == TX_END && st_ff.tx_stop2) begin
                        nxt_st.tx_stop2 = 1'b0;
                    end else if (can_start) begin
                        tx_pop         = 1'b1;
                        nxt_st.tx_sh   = tx_head;
                        nxt_st.tx_par  = par_calc(tx_head, eight, st_ff.ctrl2[C2_ODD])
                                         ^ st_ff.ctrl2[C2_BADP];
                        nxt_st.tx_bit  = 3'h0;
                        nxt_st.tx_line = 1'b0;
                        nxt_st.tx_st   = TX_DATA;
                    end else begin
                        nxt_st.tx_line = 1'b1;
                        nxt_st.tx_st   = TX_IDLE;
                    end
                end
            endcase
        end

        // receive line: infrared pulses stretched to a full low bit
        if (st_ff.rx_s2) begin
            nxt_st.ir_cnt = IR_STRETCH;
        end else if (tick16 && st_ff.ir_cnt != '0) begin
            nxt_st.ir_cnt = st_ff.ir_cnt - 1'b1;
        end
        if (!st_ff.port[PT_RXGP]) begin
            line_in = st_ff.ctrl1[C1_IR] ? (st_ff.ir_cnt == '0 && !st_ff.rx_s2)
                                         : st_ff.rx_s2;
        end

        // receiver with 3-sample majority vote
        nxt_st.rx_push = 1'b0;
        if (!en) begin
            nxt_st.rx_st    = RX_IDLE;
            nxt_st.rx_armed = 1'b0;
        end else if (tick16) begin
            if (st_ff.rx_st == RX_IDLE) begin
                if (line_in) begin
                    nxt_st.rx_armed = 1'b1;
                end else if (st_ff.rx_armed) begin
                    nxt_st.rx_st    = RX_START;
                    nxt_st.rxsub    = 4'h0;
                    nxt_st.rx_votes = 2'h0;
                    nxt_st.rx_armed = 1'b0;
                end
            end else begin
                if (st_ff.rxsub >= VOTE_FIRST && st_ff.rxsub <= VOTE_LAST) begin
                    nxt_st.rx_votes = st_ff.rx_votes + {1'b0, line_in};
                end
                if (st_ff.rxsub == VOTE_LAST) begin
                    bitv            = (st_ff.rx_votes + {1'b0, line_in}) >= 2'h2;
                    nxt_st.rx_votes = 2'h0;
                    case (st_ff.rx_st)
                        RX_START: begin
                            nxt_st.rx_st  = bitv ? RX_IDLE : RX_DATA;
                            nxt_st.rx_bit = 3'h0;
                        end
                        RX_DATA: begin
                            nxt_st.rx_sh  = {bitv, st_ff.rx_sh[7:1]};
                            nxt_st.rx_bit = st_ff.rx_bit + 1'b1;
                            if (st_ff.rx_bit == last_bit) begin
                                nxt_st.rx_st = st_ff.ctrl2[C2_PAR] ? RX_PAR : RX_STOP;
                            end
                        end
                        RX_PAR: begin
                            nxt_st.rx_par = bitv;
                            nxt_st.rx_st  = RX_STOP;
                        end
                        default: begin
                            rdata = eight ? st_ff.rx_sh : {1'b0, st_ff.rx_sh[7:1]};
                            perr  = st_ff.ctrl2[C2_PAR] &&
                                    (st_ff.rx_par != par_calc(rdata, eight, st_ff.ctrl2[C2_ODD]));
                            ferr  = !bitv;
                            brk   = !bitv && rdata == 8'h00 &&
                                    !(st_ff.ctrl2[C2_PAR] && st_ff.rx_par);
                            nxt_st.rx_word  = {brk, ferr, perr, rdata};
                            nxt_st.rx_push  = 1'b1;
                            nxt_st.rx_st    = RX_IDLE;
                            nxt_st.rx_armed = bitv;
                        end
                    endcase
                end
            end
        end

        // sticky status, set wins over software clear
        if (req_take && wb_we_i && wb_adr_i == ADR_STAT && wb_sel_i[0]) begin
            nxt_st.delta    = st_ff.delta & ~wr[ST_DELTA];
            nxt_st.ovr      = st_ff.ovr & ~wr[ST_OVR];
            nxt_st.brk_seen = st_ff.brk_seen & ~wr[ST_BRK];
        end
        if (FLOW_PINS && st_ff.req_s2 != st_ff.req_prev) begin
            nxt_st.delta = 1'b1;
        end
        if (st_ff.rx_push && !rx_room) begin
            nxt_st.ovr = 1'b1;
        end
        if (st_ff.rx_push && st_ff.rx_word[RXW_BRK]) begin
            nxt_st.brk_seen = 1'b1;
        end

        // wishbone: answer one cycle after the request is taken
        nxt_st.ack = req_take;
        if (req_take && wb_we_i) begin
            if (wb_adr_i == ADR_TXD) begin
                tx_push = wb_sel_i[0];
            end else if (wb_adr_i == ADR_CTRL1 && wb_sel_i[0]) begin
                nxt_st.ctrl1 = wr;
            end else if (wb_adr_i == ADR_CTRL2 && wb_sel_i[0]) begin
                nxt_st.ctrl2 = wr;
            end else if (wb_adr_i == ADR_DIV) begin
                if (wb_sel_i[0]) begin
                    nxt_st.div[7:0] = wr;
                end
                if (wb_sel_i[1]) begin
                    nxt_st.div[DIV_W-1:8] = wb_dat_i[DIV_W-1:8];
                end
            end else if (wb_adr_i == ADR_PORT && wb_sel_i[0]) begin
                nxt_st.port = wr[5:0];
            end
        end
        if (req_take && !wb_we_i) begin
            nxt_st.dat = 32'h0000_0000;
            if (wb_adr_i == ADR_RXD) begin
                rx_pop     = rx_avail;
                nxt_st.dat = {20'h00000, rx_avail, rx_avail ? rx_head : {RXW_W{1'b0}}};
            end else if (wb_adr_i == ADR_CTRL1) begin
                nxt_st.dat[7:0] = st_ff.ctrl1;
            end else if (wb_adr_i == ADR_CTRL2) begin
                nxt_st.dat[7:0] = st_ff.ctrl2;
            end else if (wb_adr_i == ADR_DIV) begin
                nxt_st.dat[DIV_W-1:0] = st_ff.div;
            end else if (wb_adr_i == ADR_STAT) begin
                nxt_st.dat[6:0] = {st_ff.brk_seen,
                                   st_ff.tx_st == TX_IDLE && !tx_avail,
                                   st_ff.ovr, st_ff.delta,
                                   st_ff.req_s2,
                                   rx_avail, tx_room};
            end else if (wb_adr_i == ADR_PORT) begin
                nxt_st.dat[7:0] = {st_ff.rx_s2, st_ff.txp_s2, st_ff.port};
            end
        end

        // pin drivers
        if (st_ff.ctrl1[C1_BRK] && st_ff.tx_st == TX_IDLE) begin
            tx_val = 1'b0;
        end else begin
            tx_val = st_ff.tx_line;
        end
        if (st_ff.port[PT_TXGP]) begin
            nxt_st.tx_o  = st_ff.port[PT_TXOUT];
            nxt_st.tx_oe = st_ff.port[PT_TXDIR];
        end else begin
            nxt_st.tx_oe = 1'b1;
            nxt_st.tx_o  = st_ff.ctrl1[C1_IR] ? (!tx_val && st_ff.txsub < IR_PULSE)
                                              : tx_val;
        end
        nxt_st.rx_o  = st_ff.port[PT_RXOUT];
        nxt_st.rx_oe = st_ff.port[PT_RXGP] && st_ff.port[PT_RXDIR];
        if (!FLOW_PINS) begin
            nxt_st.cts_n = 1'b1;
        end else if (st_ff.ctrl2[C2_CGP]) begin
            nxt_st.cts_n = st_ff.ctrl2[C2_CLVL];
        end else begin
            nxt_st.cts_n = !rx_room;
        end

        // interrupt requests
        nxt_st.tx_irq  = st_ff.ctrl1[C1_TXIE] && tx_room;
        nxt_st.rx_irq  = st_ff.ctrl1[C1_RXIE] && rx_avail;
        nxt_st.req_irq = st_ff.ctrl1[C1_RDIE] && st_ff.delta;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // outputs
    assign wb_dat_o     = st_ff.dat;
    assign wb_ack_o     = st_ff.ack;
    assign tx_pin_o     = st_ff.tx_o;
    assign tx_pin_oe    = st_ff.tx_oe;
    assign rx_pin_o     = st_ff.rx_o;
    assign rx_pin_oe    = st_ff.rx_oe;
    assign clear_send_n = st_ff.cts_n;
    assign tx_irq       = st_ff.tx_irq;
    assign rx_irq       = st_ff.rx_irq;
    assign request_irq  = st_ff.req_irq;

endmodule : async_serial_channel_tx_flow

/* File: design/chan_fifo.sv */
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   a push into a full FIFO is refused (in_ready low)
`timescale 1ns/1ps
module chan_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("chan_fifo depth must be a power of two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_s;

    fifo_s st_ff;
    fifo_s nxt_st;
    logic  do_push;
    logic  do_pop;

    // ==========================================================
    // next state
    always_comb begin
        nxt_st  = st_ff;
        do_push = in_valid && in_ready;
        do_pop  = out_valid && out_ready;
        if (do_push) begin
            nxt_st.mem[st_ff.wp] = in_data;
            nxt_st.wp            = st_ff.wp + 1'b1;
        end
        if (do_pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign in_ready  = (st_ff.cnt != DEPTH[AW:0]);
    assign out_valid = (st_ff.cnt != '0);
    assign out_data  = st_ff.mem[st_ff.rp];

endmodule : chan_fifo

/* File: design/uart_chan_pkg.sv */
// Purpose: shared constants, states and helpers of the serial channel
// Assumes: 32-bit classic Wishbone, byte addresses, one register per word
// Notes:   divisor field holds ratio minus one, so 0..4095 selects 1..4096
package uart_chan_pkg;

    // ==========================================================
    // sizes
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned DIV_W      = 12;
    localparam int unsigned RXW_W      = 11;
    localparam int unsigned CLK_HZ     = 20_000_000;
    localparam int unsigned BPS_MIN    = 300;
    localparam int unsigned BPS_MAX    = 115_200;

    // ==========================================================
    // register offsets
    localparam logic [4:0] ADR_RXD   = 5'h00;
    localparam logic [4:0] ADR_TXD   = 5'h04;
    localparam logic [4:0] ADR_CTRL1 = 5'h08;
    localparam logic [4:0] ADR_CTRL2 = 5'h0c;
    localparam logic [4:0] ADR_DIV   = 5'h10;
    localparam logic [4:0] ADR_STAT  = 5'h14;
    localparam logic [4:0] ADR_PORT  = 5'h18;

    // ==========================================================
    // field positions
    localparam int C1_EN = 0, C1_TXIE = 1, C1_RXIE = 2, C1_RDIE = 3, C1_IR = 4, C1_BRK = 5;
    localparam int C2_EIGHT = 0, C2_PAR = 1, C2_ODD = 2, C2_TWO = 3, C2_IGN = 4;
    localparam int C2_CGP = 5, C2_CLVL = 6, C2_BADP = 7;
    localparam int ST_TXRDY = 0, ST_RXRDY = 1, ST_REQLVL = 2, ST_DELTA = 3;
    localparam int ST_OVR = 4, ST_TXIDLE = 5, ST_BRK = 6;
    localparam int PT_TXGP = 0, PT_RXGP = 1, PT_TXDIR = 2, PT_RXDIR = 3;
    localparam int PT_TXOUT = 4, PT_RXOUT = 5, PT_TXIN = 6, PT_RXIN = 7;
    localparam int RXW_PERR = 8, RXW_FERR = 9, RXW_BRK = 10, RXD_VALID = 11;

    // ==========================================================
    // reset values and sub-bit timing
    localparam logic [7:0]       CTRL1_RST = 8'h00;
    localparam logic [7:0]       CTRL2_RST = 8'h01;
    localparam logic [DIV_W-1:0] DIV_RST   = 12'h000;
    localparam logic [5:0]       PORT_RST  = 6'h00;
    localparam logic [3:0]       SUB_LAST   = 4'hf;
    localparam logic [3:0]       IR_PULSE   = 4'h3;
    localparam logic [3:0]       VOTE_FIRST = 4'h7;
    localparam logic [3:0]       VOTE_LAST  = 4'h9;
    localparam logic [3:0]       IR_STRETCH = 4'hf;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000, TX_DATA = 3'b001, TX_PAR = 3'b010, TX_STOP = 3'b011, TX_END = 3'b100
    } tx_state_e;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011, RX_STOP = 3'b100
    } rx_state_e;

    // parity over 7 or 8 data bits, even unless odd is set
    function automatic logic par_calc(input logic [7:0] d, input logic eight, input logic odd);
        par_calc = (^{d[7] & eight, d[6:0]}) ^ odd;
    endfunction : par_calc

endpackage : uart_chan_pkg
